// *** rtl/iod_decoder.v ***
// Instruction opcode decoder top: takes bytes from the fetch queue, collects
// operand bytes and hands one decoded instruction at a time to execution.
// Assumes a byte handshake on FQ_VALID/FQ_READY, EX_READY from execution,
// and an APB master for the control and status registers.
//
// Functional notes
// - Opcode FD sets direction flag, no operands
// - Opcode FB sets interrupt-enable flag, no operands
// - 84/85 flag-only conjunction, addressing byte, no write
// - F6/F7 needs middle field 000, imm 1/2
// - A8/A9 accumulator conjunction, immediate low then high
// - 28-2B subtract, direction and width bits, addressing
// - D7 table lookup, result to accumulator low byte
// - Prefix 26 selects extra segment for next
// - Prefix 36 selects stack segment for next
//
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/1ns
`include "iod_regs.vh"

module iod_decoder (
   input wire CLK,               // Core clock, 20 MHz
   input wire RESET,             // Synchronous reset, active high
   input wire FQ_VALID,          // Fetch queue byte available
   input wire [7:0] FQ_BYTE,     // Fetch queue byte
   output reg FQ_READY,          // Decoder takes a byte
   output reg EX_VALID,          // Decoded instruction available
   input wire EX_READY,          // Execution takes the instruction
   output reg [3:0] EX_OP,       // Decoded operation
   output reg [7:0] EX_OPCODE,   // Raw opcode byte
   output reg EX_HAS_MODRM,      // Addressing-form byte present
   output reg [7:0] EX_MODRM,    // Addressing-form byte
   output reg [15:0] EX_DISP,    // Displacement, sign-extended if 8-bit
   output reg [15:0] EX_IMM,     // Immediate, extended if 8-bit
   output reg EX_WIDE,           // Word operation
   output reg EX_TO_REG,         // Register field is destination
   output reg [1:0] EX_SEG,      // Segment override for memory operand
   output reg EX_FLAGS_ONLY,     // Update flags, write no result
   output reg EX_SET_DF,         // Set direction flag
   output reg EX_SET_IF,         // Set interrupt-enable flag
   output reg EX_DEST_AL,        // Result goes to accumulator low byte
   output reg EX_INVALID,        // Opcode not decodable
   input wire PSEL,              // APB select
   input wire PENABLE,           // APB access phase
   input wire PWRITE,            // APB write
   input wire [11:0] PADDR,      // APB byte address
   input wire [31:0] PWDATA,     // APB write data
   output reg [31:0] PRDATA,     // APB read data
   output reg PREADY,            // APB ready
   output reg PSLVERR            // APB error on unmapped address
);

   // ------------------------------------------------------------
   // States
   // ------------------------------------------------------------
   localparam [2:0] S_OPC = 3'h0;
   localparam [2:0] S_MODRM = 3'h1;
   localparam [2:0] S_DLO = 3'h2;
   localparam [2:0] S_DHI = 3'h3;
   localparam [2:0] S_ILO = 3'h4;
   localparam [2:0] S_IHI = 3'h5;
   localparam [2:0] S_OUT = 3'h6;

   reg [2:0] state;
   reg [2:0] next_state;
   reg [1:0] seg_pend;
   reg [1:0] imm_kind;
   reg [1:0] grp;
   reg [1:0] disp_len;
   reg ctrl_en;
   reg [15:0] cnt_issued;
   reg [15:0] cnt_invalid;

   wire take = FQ_VALID & FQ_READY;
   wire [7:0] cls_byte = (state == S_OPC) ? FQ_BYTE : EX_OPCODE;
   wire [7:0] mrm_byte = (state == S_MODRM) ? FQ_BYTE : EX_MODRM;
   wire [3:0] c_op;
   wire c_modrm;
   wire [1:0] c_imm;
   wire [1:0] c_grp;
   wire [1:0] c_prefix;
   wire c_invalid;
   wire [1:0] m_disp;
   wire [3:0] m_op;
   wire m_bad;

   iod_classify u_classify (
      .opcode(cls_byte),
      .op(c_op),
      .has_modrm(c_modrm),
      .imm_kind(c_imm),
      .grp(c_grp),
      .prefix(c_prefix),
      .invalid(c_invalid)
   );

   iod_modrm u_modrm (
      .modrm(mrm_byte),
      .grp(grp),
      .disp_len(m_disp),
      .grp_op(m_op),
      .reg_bad(m_bad)
   );

   wire is_prefix = (c_prefix != `IOD_SEG_DEFAULT);
   wire issue = (next_state == S_OUT) && (state != S_OUT);

   // ------------------------------------------------------------
   // Byte sequencing
   // ------------------------------------------------------------
   always @* begin
      next_state = state;
      case (state)
         S_OPC: begin
            if (take && !is_prefix) begin
               if (c_invalid) begin
                  next_state = S_OUT;
               end else if (c_modrm) begin
                  next_state = S_MODRM;
               end else if (c_imm != `IOD_IMM_NONE) begin
                  next_state = S_ILO;
               end else begin
                  next_state = S_OUT;
               end
            end
         end
         S_MODRM: begin
            if (take) begin
               if (m_bad) begin
                  next_state = S_OUT;
               end else if (m_disp != 2'h0) begin
                  next_state = S_DLO;
               end else if (imm_kind != `IOD_IMM_NONE) begin
                  next_state = S_ILO;
               end else begin
                  next_state = S_OUT;
               end
            end
         end
         S_DLO: begin
            if (take) begin
               if (disp_len == 2'h2) begin
                  next_state = S_DHI;
               end else if (imm_kind != `IOD_IMM_NONE) begin
                  next_state = S_ILO;
               end else begin
                  next_state = S_OUT;
               end
            end
         end
         S_DHI: begin
            if (take) begin
               next_state = (imm_kind != `IOD_IMM_NONE) ? S_ILO : S_OUT;
            end
         end
         S_ILO: begin
            if (take) begin
               next_state = (imm_kind == `IOD_IMM_WORD) ? S_IHI : S_OUT;
            end
         end
         S_IHI: begin
            if (take) begin
               next_state = S_OUT;
            end
         end
         S_OUT: begin
            if (EX_READY) begin
               next_state = S_OPC;
            end
         end
         default: begin
            next_state = S_OPC;
         end
      endcase
   end

   // ------------------------------------------------------------
   // Instruction fields
   // ------------------------------------------------------------
   always @(posedge CLK) begin
      if (RESET) begin
         state <= S_OPC;
         FQ_READY <= 1'b0;
         EX_VALID <= 1'b0;
         seg_pend <= `IOD_SEG_DEFAULT;
         imm_kind <= `IOD_IMM_NONE;
         grp <= `IOD_GRP_NONE;
         disp_len <= 2'h0;
         EX_OP <= `IOD_OP_NONE;
         EX_OPCODE <= 8'h00;
         EX_HAS_MODRM <= 1'b0;
         EX_MODRM <= 8'h00;
         EX_DISP <= 16'h0000;
         EX_IMM <= 16'h0000;
         EX_WIDE <= 1'b0;
         EX_TO_REG <= 1'b0;
         EX_SEG <= `IOD_SEG_DEFAULT;
         EX_FLAGS_ONLY <= 1'b0;
         EX_SET_DF <= 1'b0;
         EX_SET_IF <= 1'b0;
         EX_DEST_AL <= 1'b0;
         EX_INVALID <= 1'b0;
      end else begin
         state <= next_state;
         // Ready drops while an instruction waits, so bytes back up in the queue
         FQ_READY <= ctrl_en && (next_state != S_OUT);
         if (issue) begin
            EX_VALID <= 1'b1;
         end else if (state == S_OUT && EX_READY) begin
            EX_VALID <= 1'b0;
         end
         if (state == S_OPC && take) begin
            if (is_prefix) begin
               // A later prefix replaces an earlier one
               seg_pend <= c_prefix;
            end else begin
               EX_OPCODE <= FQ_BYTE;
               EX_OP <= c_op;
               EX_HAS_MODRM <= c_modrm;
               EX_MODRM <= 8'h00;
               EX_DISP <= 16'h0000;
               EX_IMM <= 16'h0000;
               imm_kind <= c_imm;
               grp <= c_grp;
               EX_WIDE <= (c_op == `IOD_OP_TABLE) ? 1'b0 : FQ_BYTE[0];
               EX_TO_REG <= c_modrm && (c_grp == `IOD_GRP_NONE) && FQ_BYTE[1];
               EX_SEG <= seg_pend;
               seg_pend <= `IOD_SEG_DEFAULT;
               EX_FLAGS_ONLY <= (c_op == `IOD_OP_TEST);
               EX_SET_DF <= (c_op == `IOD_OP_SET_DF);
               EX_SET_IF <= (c_op == `IOD_OP_SET_IF);
               EX_DEST_AL <= (c_op == `IOD_OP_TABLE);
               EX_INVALID <= c_invalid;
            end
         end
         if (state == S_MODRM && take) begin
            EX_MODRM <= FQ_BYTE;
            disp_len <= m_disp;
            if (grp == `IOD_GRP_ARITH) begin
               EX_OP <= m_op;
            end
            if (m_bad) begin
               EX_INVALID <= 1'b1;
               EX_OP <= `IOD_OP_NONE;
            end
         end
         if (state == S_DLO && take) begin
            EX_DISP <= {{8{FQ_BYTE[7] & (disp_len == 2'h1)}}, FQ_BYTE};
         end
         if (state == S_DHI && take) begin
            EX_DISP[15:8] <= FQ_BYTE;
         end
         if (state == S_ILO && take) begin
            EX_IMM <= {{8{FQ_BYTE[7] & (imm_kind == `IOD_IMM_SEXT)}}, FQ_BYTE};
         end
         if (state == S_IHI && take) begin
            EX_IMM[15:8] <= FQ_BYTE;
         end
      end
   end

   // ------------------------------------------------------------
   // APB slave
   // ------------------------------------------------------------
   // One wait state: PREADY rises in the second access cycle
   wire apb_done = PSEL & PENABLE & PREADY;
   wire apb_wr = apb_done & PWRITE;
   wire hit_ctrl = (PADDR == `IOD_ADDR_CTRL);
   wire hit_status = (PADDR == `IOD_ADDR_STATUS);
   wire hit_count = (PADDR == `IOD_ADDR_COUNT);
   wire hit_last = (PADDR == `IOD_ADDR_LAST);
   wire mapped = hit_ctrl | hit_status | hit_count | hit_last;
   wire clr_cnt = apb_wr & hit_ctrl & PWDATA[`IOD_CTRL_CLR_BIT];
   wire issue_bad = issue & ((state == S_OPC) ? c_invalid : m_bad);

   always @(posedge CLK) begin
      if (RESET) begin
         PREADY <= 1'b0;
         PRDATA <= 32'h00000000;
         PSLVERR <= 1'b0;
         ctrl_en <= `IOD_CTRL_RESET;
         cnt_issued <= 16'h0000;
         cnt_invalid <= 16'h0000;
      end else begin
         PREADY <= PSEL & PENABLE & ~PREADY;
         if (PSEL & PENABLE & ~PREADY) begin
            PSLVERR <= ~mapped;
            PRDATA <= 32'h00000000;
            if (!PWRITE) begin
               if (hit_ctrl) begin
                  PRDATA <= {31'h00000000, ctrl_en};
               end else if (hit_status) begin
                  PRDATA <= {24'h000000, EX_VALID, seg_pend, FQ_READY, 1'b0, state};
               end else if (hit_count) begin
                  PRDATA <= {cnt_invalid, cnt_issued};
               end else if (hit_last) begin
                  PRDATA <= {16'h0000, EX_OP, 3'h0, EX_INVALID, EX_OPCODE};
               end
            end
         end else begin
            PSLVERR <= 1'b0;
         end
         if (apb_wr & hit_ctrl) begin
            ctrl_en <= PWDATA[`IOD_CTRL_EN_BIT];
         end
         // An issue in the clearing cycle still counts
         if (clr_cnt) begin
            cnt_issued <= {15'h0000, issue};
            cnt_invalid <= {15'h0000, issue_bad};
         end else begin
            cnt_issued <= cnt_issued + {15'h0000, issue};
            cnt_invalid <= cnt_invalid + {15'h0000, issue_bad};
         end
      end
   end

endmodule

// *** rtl/iod_regs.vh ***
// Constants for the instruction opcode decoder: register map, fields,
// reset values, opcode patterns and decoded operation codes.
// Assumes inclusion by bare name from the decoder modules.
`ifndef IOD_REGS_VH
`define IOD_REGS_VH

// ------------------------------------------------------------
// APB register map (byte addresses)
// ------------------------------------------------------------
`define IOD_ADDR_CTRL 12'h000
`define IOD_ADDR_STATUS 12'h004
`define IOD_ADDR_COUNT 12'h008
`define IOD_ADDR_LAST 12'h00C

`define IOD_CTRL_EN_BIT 0
`define IOD_CTRL_CLR_BIT 1
`define IOD_CTRL_RESET 1'b1

// ------------------------------------------------------------
// Opcode patterns
// ------------------------------------------------------------
`define IOD_OPC_SET_DF 8'hFD
`define IOD_OPC_SET_IF 8'hFB
`define IOD_OPC_TABLE 8'hD7
`define IOD_OPC_WAIT 8'h9B
`define IOD_OPC_PFX_EXTRA 8'h26
`define IOD_OPC_PFX_STACK 8'h36
`define IOD_TEST_IMM_REG 3'h0
`define IOD_GRP_SUB_REG 3'h5
`define IOD_GRP_XOR_REG 3'h6

// ------------------------------------------------------------
// Decoded operation codes
// ------------------------------------------------------------
`define IOD_OP_NONE 4'h0
`define IOD_OP_SET_DF 4'h1
`define IOD_OP_SET_IF 4'h2
`define IOD_OP_STR_STORE 4'h3
`define IOD_OP_SUB 4'h4
`define IOD_OP_TEST 4'h5
`define IOD_OP_WAIT 4'h6
`define IOD_OP_SWAP 4'h7
`define IOD_OP_TABLE 4'h8
`define IOD_OP_XOR 4'h9
`define IOD_OP_GROUP 4'hF

// Immediate kinds
`define IOD_IMM_NONE 2'h0
`define IOD_IMM_BYTE 2'h1
`define IOD_IMM_WORD 2'h2
`define IOD_IMM_SEXT 2'h3

// Segment override codes
`define IOD_SEG_DEFAULT 2'h0
`define IOD_SEG_EXTRA 2'h1
`define IOD_SEG_STACK 2'h2

// Group check kinds
`define IOD_GRP_NONE 2'h0
`define IOD_GRP_TEST 2'h1
`define IOD_GRP_ARITH 2'h2

`endif

// *** rtl/iod_classify.v ***
// Opcode byte classifier: pure combinational lookup of one opcode byte.
// Assumes the caller presents a stable byte and uses results the same cycle.
`timescale 1ns/1ns
`include "iod_regs.vh"

module iod_classify (
   input wire [7:0] opcode,      // Opcode byte under test
   output reg [3:0] op,          // Decoded operation
   output reg has_modrm,         // Addressing-form byte follows
   output reg [1:0] imm_kind,    // Immediate size after operand bytes
   output reg [1:0] grp,         // Middle field needs checking
   output reg [1:0] prefix,      // Segment prefix code, default if none
   output reg invalid            // Byte matches no decoded pattern
);

   always @* begin
      op = `IOD_OP_NONE;
      has_modrm = 1'b0;
      imm_kind = `IOD_IMM_NONE;
      grp = `IOD_GRP_NONE;
      prefix = `IOD_SEG_DEFAULT;
      invalid = 1'b0;
      if (opcode == `IOD_OPC_SET_DF) begin
         op = `IOD_OP_SET_DF;
      end else if (opcode == `IOD_OPC_SET_IF) begin
         op = `IOD_OP_SET_IF;
      end else if (opcode == `IOD_OPC_TABLE) begin
         op = `IOD_OP_TABLE;
      end else if (opcode == `IOD_OPC_WAIT) begin
         op = `IOD_OP_WAIT;
      end else if (opcode == `IOD_OPC_PFX_EXTRA) begin
         prefix = `IOD_SEG_EXTRA;
      end else if (opcode == `IOD_OPC_PFX_STACK) begin
         prefix = `IOD_SEG_STACK;
      end else if (opcode[7:1] == 7'h55) begin
         op = `IOD_OP_STR_STORE;
      end else if (opcode[7:1] == 7'h42) begin
         op = `IOD_OP_TEST;
         has_modrm = 1'b1;
      end else if (opcode[7:1] == 7'h7B) begin
         op = `IOD_OP_TEST;
         has_modrm = 1'b1;
         grp = `IOD_GRP_TEST;
         imm_kind = opcode[0] ? `IOD_IMM_WORD : `IOD_IMM_BYTE;
      end else if (opcode[7:1] == 7'h54) begin
         op = `IOD_OP_TEST;
         imm_kind = opcode[0] ? `IOD_IMM_WORD : `IOD_IMM_BYTE;
      end else if (opcode[7:2] == 6'h0A) begin
         op = `IOD_OP_SUB;
         has_modrm = 1'b1;
      end else if (opcode[7:1] == 7'h16) begin
         op = `IOD_OP_SUB;
         imm_kind = opcode[0] ? `IOD_IMM_WORD : `IOD_IMM_BYTE;
      end else if (opcode[7:2] == 6'h0C) begin
         op = `IOD_OP_XOR;
         has_modrm = 1'b1;
      end else if (opcode[7:1] == 7'h1A) begin
         op = `IOD_OP_XOR;
         imm_kind = opcode[0] ? `IOD_IMM_WORD : `IOD_IMM_BYTE;
      end else if (opcode[7:1] == 7'h43) begin
         op = `IOD_OP_SWAP;
         has_modrm = 1'b1;
      end else if (opcode[7:3] == 5'h12) begin
         op = `IOD_OP_SWAP;
      end else if (opcode[7:2] == 6'h20 && opcode[1:0] != 2'h2) begin
         // Sign-extend form with byte width is not a legal encoding
         op = `IOD_OP_GROUP;
         has_modrm = 1'b1;
         grp = `IOD_GRP_ARITH;
         case (opcode[1:0])
            2'h1: imm_kind = `IOD_IMM_WORD;
            2'h3: imm_kind = `IOD_IMM_SEXT;
            default: imm_kind = `IOD_IMM_BYTE;
         endcase
      end else begin
         invalid = 1'b1;
      end
   end

endmodule

// *** rtl/iod_modrm.v ***
// Addressing-form byte decoder: displacement length and middle-field check.
// Assumes the group kind comes from the classifier for the same instruction.
`timescale 1ns/1ns
`include "iod_regs.vh"

module iod_modrm (
   input wire [7:0] modrm,       // Addressing-form byte
   input wire [1:0] grp,         // Middle field check kind
   output reg [1:0] disp_len,    // Displacement bytes, 0 to 2
   output reg [3:0] grp_op,      // Operation chosen by middle field
   output reg reg_bad            // Middle field not allowed
);

   always @* begin
      case (modrm[7:6])
         2'h0: disp_len = (modrm[2:0] == 3'h6) ? 2'h2 : 2'h0;
         2'h1: disp_len = 2'h1;
         2'h2: disp_len = 2'h2;
         default: disp_len = 2'h0;
      endcase
      grp_op = `IOD_OP_NONE;
      reg_bad = 1'b0;
      case (grp)
         `IOD_GRP_TEST: begin
            reg_bad = (modrm[5:3] != `IOD_TEST_IMM_REG);
         end
         `IOD_GRP_ARITH: begin
            if (modrm[5:3] == `IOD_GRP_SUB_REG) begin
               grp_op = `IOD_OP_SUB;
            end else if (modrm[5:3] == `IOD_GRP_XOR_REG) begin
               grp_op = `IOD_OP_XOR;
            end else begin
               reg_bad = 1'b1;
            end
         end
         default: begin
            reg_bad = 1'b0;
         end
      endcase
   end

endmodule

// *** verification/iod_decoder_properties.sv ***
// Checker for the opcode decoder, watching only the top module ports.
// Assumes it is attached to every decoder instance by the bind at the foot.
`timescale 1ns/1ns

module iod_decoder_properties (
   input wire CLK,             // Core clock
   input wire RESET,           // Synchronous reset
   input wire FQ_READY,        // Byte taken
   input wire EX_VALID,        // Instruction issued
   input wire EX_READY,        // Instruction taken
   input wire [3:0] EX_OP,     // Operation
   input wire [7:0] EX_OPCODE, // Raw opcode
   input wire EX_HAS_MODRM,    // Addressing byte present
   input wire [7:0] EX_MODRM,  // Addressing byte
   input wire [15:0] EX_IMM,   // Immediate
   input wire EX_WIDE,         // Word operation
   input wire EX_TO_REG,       // Register is destination
   input wire EX_FLAGS_ONLY,   // No result written
   input wire EX_SET_DF,       // Direction flag set
   input wire EX_SET_IF,       // Interrupt-enable flag set
   input wire EX_DEST_AL,      // Result to accumulator low byte
   input wire EX_INVALID,      // Undecodable
   input wire PSEL,            // APB select
   input wire PENABLE,         // APB access phase
   input wire PREADY           // APB ready
);
   default clocking @(posedge CLK); endclocking
   default disable iff (RESET);
   sequence s_held; EX_VALID && !EX_READY; endsequence
   sequence s_take; EX_VALID && EX_READY; endsequence
   sequence s_setup; PSEL && !PENABLE; endsequence
   property p_hold; s_held |=> EX_VALID && $stable(EX_OP) && $stable(EX_IMM) && $stable(EX_OPCODE); endproperty
   property p_take; s_take |=> !EX_VALID; endproperty
   property p_stall; EX_VALID |-> !FQ_READY; endproperty
   property p_df; EX_VALID && EX_OPCODE == 8'hFD |-> EX_SET_DF && EX_OP == 4'h1 && !EX_HAS_MODRM; endproperty
   property p_if; EX_VALID && EX_OPCODE == 8'hFB |-> EX_SET_IF && EX_OP == 4'h2; endproperty
   property p_trm; EX_VALID && EX_OPCODE[7:1] == 7'h42 |-> EX_OP == 4'h5 && EX_FLAGS_ONLY && EX_HAS_MODRM; endproperty
   property p_timm; EX_VALID && EX_OPCODE[7:1] == 7'h7B |-> EX_INVALID == (EX_MODRM[5:3] != 3'h0); endproperty
   property p_acc;
      EX_VALID && EX_OPCODE[7:1] == 7'h54 |-> !EX_HAS_MODRM && EX_FLAGS_ONLY && (EX_OPCODE[0] || EX_IMM[15:8] == 8'h00);
   endproperty
   property p_sub;
      EX_VALID && EX_OPCODE[7:2] == 6'h0A |-> EX_OP == 4'h4 && EX_TO_REG == EX_OPCODE[1] && EX_WIDE == EX_OPCODE[0];
   endproperty
   property p_tbl; EX_VALID && EX_OPCODE == 8'hD7 |-> EX_DEST_AL && EX_OP == 4'h8; endproperty
   property p_bad; EX_VALID && EX_OPCODE == 8'h0F |-> EX_INVALID; endproperty
   property p_apb; s_setup ##1 PSEL && PENABLE |-> !PREADY ##1 PREADY; endproperty
   a_hold: assert property (p_hold) else $error("fields moved");
   a_take: assert property (p_take) else $error("issue did not end at take");
   a_stall: assert property (p_stall) else $error("byte taken while held");
   a_df: assert property (p_df) else $error("FD misdecoded");
   a_if: assert property (p_if) else $error("FB misdecoded");
   a_trm: assert property (p_trm) else $error("flag-only form misdecoded");
   a_timm: assert property (p_timm) else $error("middle field check wrong");
   a_acc: assert property (p_acc) else $error("accumulator form misdecoded");
   a_sub: assert property (p_sub) else $error("subtract bits misdecoded");
   a_tbl: assert property (p_tbl) else $error("table lookup misdecoded");
   a_bad: assert property (p_bad) else $error("reserved opcode not flagged");
   a_apb: assert property (p_apb) else $error("APB wait state wrong");
endmodule

bind iod_decoder iod_decoder_properties i_props (.CLK, .RESET, .FQ_READY, .EX_VALID, .EX_READY, .EX_OP, .EX_OPCODE,
   .EX_HAS_MODRM, .EX_MODRM, .EX_IMM, .EX_WIDE, .EX_TO_REG, .EX_FLAGS_ONLY, .EX_SET_DF, .EX_SET_IF, .EX_DEST_AL,
   .EX_INVALID, .PSEL, .PENABLE, .PREADY);

// *** verification/iod_fq_model.sv ***
// Fetch queue and execution partner for the opcode decoder.
// Assumes the bench loads bytes with push and raises slow to stall execution.
`timescale 1ns/1ns

module iod_fq_model (
   input wire CLK,             // Core clock
   input wire RESET,           // Synchronous reset
   input wire FQ_READY,        // Decoder takes a byte
   input wire slow,            // Stall execution every other cycle
   output logic FQ_VALID,      // Byte available
   output logic [7:0] FQ_BYTE, // Byte offered
   output logic EX_READY       // Execution takes the instruction
);
   logic [7:0] q[$];
   logic tog = 1'b0;
   initial begin
      FQ_VALID = 1'b0;
      FQ_BYTE = 8'h00;
      EX_READY = 1'b0;
   end
   task push(input logic [7:0] b);
      q.push_back(b);
   endtask
   always @(posedge CLK) begin
      if (RESET) begin
         FQ_VALID <= 1'b0;
         EX_READY <= 1'b0;
      end else begin
         if (FQ_VALID && FQ_READY)
            void'(q.pop_front());
         if (q.size() > 0) begin
            FQ_VALID <= 1'b1;
            FQ_BYTE <= q[0];
         end else begin
            // Idle line toggles so a stale byte is never mistaken for data
            FQ_VALID <= 1'b0;
            FQ_BYTE <= ~FQ_BYTE;
         end
         tog <= ~tog;
         EX_READY <= slow ? tog : 1'b1;
      end
   end
endmodule

// *** verification/tb_top.sv ***
// Bench for the opcode decoder: feeds opcode streams, drives APB, checks issue.
// Assumes the partner model supplies bytes and the checker is bound to the top.
`timescale 1ns/1ns
`include "iod_regs.vh"

module tb_top;
   logic CLK = 1'b0;
   logic RESET = 1'b1;
   logic slow = 1'b0;
   logic PSEL = 1'b0;
   logic PENABLE = 1'b0;
   logic PWRITE = 1'b0;
   logic [11:0] PADDR = 12'h000;
   logic [31:0] PWDATA = 32'h00000000;
   wire FQ_VALID, FQ_READY, EX_VALID, EX_READY, EX_HAS_MODRM, EX_WIDE, EX_TO_REG, EX_FLAGS_ONLY;
   wire EX_SET_DF, EX_SET_IF, EX_DEST_AL, EX_INVALID, PREADY, PSLVERR;
   wire [7:0] FQ_BYTE, EX_OPCODE, EX_MODRM;
   wire [3:0] EX_OP;
   wire [15:0] EX_DISP, EX_IMM;
   wire [1:0] EX_SEG;
   wire [31:0] PRDATA;
   int n_fail = 0;
   int total_checks = 0;
   always #25 CLK = ~CLK;
   iod_decoder i_iod_decoder (.CLK, .RESET, .FQ_VALID, .FQ_BYTE, .FQ_READY, .EX_VALID, .EX_READY, .EX_OP, .EX_OPCODE,
      .EX_HAS_MODRM, .EX_MODRM, .EX_DISP, .EX_IMM, .EX_WIDE, .EX_TO_REG, .EX_SEG, .EX_FLAGS_ONLY, .EX_SET_DF,
      .EX_SET_IF, .EX_DEST_AL, .EX_INVALID, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR);
   iod_fq_model i_iod_fq_model (.CLK, .RESET, .FQ_READY, .slow, .FQ_VALID, .FQ_BYTE, .EX_READY);
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task chk(input logic [47:0] g, input logic [47:0] e, input string m);
      total_checks++;
      if (g !== e) begin
         n_fail++;
         $display("FAIL %0t %s got %h want %h", $time, m, g, e);
      end
   endtask
   task feed(input logic [47:0] w, input int n);
      for (int i = 0; i < n; i++)
         i_iod_fq_model.push(w[8*(n-i)-1 -: 8]);
   endtask
   // Returns at the falling edge before the taking edge, while fields stand
   task take;
      int k;
      for (k = 0; k < 100; k++) begin
         @(negedge CLK);
         if (EX_VALID === 1'b1 && EX_READY === 1'b1)
            break;
      end
      chk(k < 100, 1'b1, "no issue");
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
      int k;
      @(posedge CLK);
      PSEL <= 1'b1;
      PENABLE <= 1'b0;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      for (k = 0; k < 20; k++) begin
         @(posedge CLK);
         if (PREADY === 1'b1)
            break;
      end
      r = PRDATA;
      e = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      chk(k < 20, 1'b1, "no pready");
   endtask
   task end_of_test;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task t_regs;
      logic [31:0] r;
      logic e;
      apb(1'b0, `IOD_ADDR_CTRL, 32'h0, r, e);
      chk(r, 32'h00000001, "ctrl reset");
      apb(1'b1, `IOD_ADDR_CTRL, 32'h00000002, r, e);
      @(posedge CLK);
      feed(48'hFD, 1);
      repeat (6) @(posedge CLK);
      @(negedge CLK);
      chk({FQ_READY, EX_VALID}, 2'b00, "taken while off");
      apb(1'b1, `IOD_ADDR_CTRL, 32'h00000001, r, e);
      take;
      chk({EX_OP, EX_SET_DF}, {4'h1, 1'b1}, "byte after enable");
      apb(1'b0, `IOD_ADDR_COUNT, 32'h0, r, e);
      chk(r, 32'h00000001, "count after clear");
      apb(1'b0, `IOD_ADDR_LAST, 32'h0, r, e);
      chk(r, 32'h000010FD, "last fields");
      apb(1'b0, 12'h010, 32'h0, r, e);
      chk({e, r}, 33'h100000000, "unmapped read");
   endtask
   task t_flags;
      feed(48'hFBFD, 2);
      take;
      chk({EX_OP, EX_SET_IF, EX_HAS_MODRM}, {4'h2, 2'b10}, "set if");
      take;
      chk({EX_OP, EX_SET_DF, EX_SET_IF}, {4'h1, 2'b10}, "df back to back");
   endtask
   task t_test;
      feed(48'h85C0F7C13412, 6);
      take;
      chk({EX_OP, EX_FLAGS_ONLY, EX_HAS_MODRM, EX_WIDE}, {4'h5, 3'b111}, "test reg form");
      take;
      chk({EX_OP, EX_FLAGS_ONLY, EX_IMM, EX_INVALID}, {4'h5, 1'b1, 16'h1234, 1'b0}, "test imm word");
      feed(48'hF6C05AF6C8FB, 6);
      take;
      chk({EX_IMM, EX_WIDE}, {16'h005A, 1'b0}, "test imm byte");
      take;
      chk(EX_INVALID, 1'b1, "middle field not zero");
      take;
      chk(EX_OP, 4'h2, "no imm after bad");
   endtask
   task t_acc;
      feed(48'hA93412A87F, 5);
      take;
      chk({EX_OP, EX_IMM, EX_HAS_MODRM, EX_FLAGS_ONLY}, {4'h5, 16'h1234, 2'b01}, "acc word");
      take;
      chk({EX_IMM, EX_WIDE}, {16'h007F, 1'b0}, "acc byte");
   endtask
   task t_sub;
      slow <= 1'b1;
      feed(48'h2B46802806, 5);
      feed(48'h3412, 2);
      take;
      chk({EX_OP, EX_TO_REG, EX_WIDE, EX_DISP}, {4'h4, 2'b11, 16'hFF80}, "sub to reg word");
      take;
      chk({EX_TO_REG, EX_WIDE, EX_MODRM, EX_DISP}, {2'b00, 8'h06, 16'h1234}, "sub to rm byte");
      slow <= 1'b0;
   endtask
   task t_table;
      feed(48'hD7, 1);
      take;
      chk({EX_OP, EX_DEST_AL, EX_HAS_MODRM}, {4'h8, 2'b10}, "table lookup");
   endtask
   task t_prefix;
      feed(48'h2685060010, 5);
      take;
      chk({EX_SEG, EX_DISP}, {2'h1, 16'h1000}, "extra segment");
      feed(48'h263684C0, 4);
      take;
      chk(EX_SEG, 2'h2, "last prefix wins");
      feed(48'h84C0, 2);
      take;
      chk(EX_SEG, 2'h0, "override once");
   endtask
   task t_invalid;
      feed(48'h0F63FD, 3);
      take;
      chk(EX_INVALID, 1'b1, "reserved 0F");
      take;
      chk(EX_INVALID, 1'b1, "reserved 63");
      take;
      chk({EX_OP, EX_INVALID}, {4'h1, 1'b0}, "next opcode intact");
   endtask

   initial begin
      repeat (12) @(posedge CLK);
      RESET <= 1'b0;
      @(posedge CLK);
      t_flags;
      t_test;
      t_acc;
      t_sub;
      t_table;
      t_prefix;
      t_invalid;
      t_regs;
      end_of_test;
   end
   initial begin
      repeat (5000) @(posedge CLK);
      n_fail++;
      $display("FAIL %0t watchdog expired", $time);
      end_of_test;
   end
endmodule
